// [verilog/esb_spare_hdlc2.sv]
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: Spare captures hold last multiframe, reset zero
// R2: Bit 7 frame 1, bit 6 frame 3
// R3: Capture updates only when position select set
// R4: Hardware keeps reserved control bit 7 zero
// R5: Auto abort sends zero plus seven ones
// R6: Abort disabled: switch to bit pattern directly
// R7: Receive checksum verified unless check disabled
// R8: Duplicate frames dropped when drop enabled
// R9: Forced abort sends continuous ones
// R10: Select bit zero means bit pattern mode
// R11: Host writes to spare captures ignored
module esb_spare_hdlc2 #(
    parameter int RX_DEPTH = 32
) (
    // Clock, reset, enable
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          ce,
    // AHB-Lite slave
    input  wire logic                          hsel,
    input  wire logic [esb_pkg::ESB_ADDR_W-1:0] haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic                          hready,
    input  wire logic [31:0]                   hwdata,
    output logic [31:0]                        hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    // Received spare bits from the framer
    input  wire logic                          sa_tick,
    input  wire logic [3:0]                    sa_frame,
    input  wire logic [3:0]                    sa_bits,
    // Receive data link
    input  wire logic                          rx_dl_tick,
    input  wire logic                          rx_dl_bit,
    // Transmit data link
    input  wire logic                          tx_dl_tick,
    input  wire logic [5:0]                    bos_code,
    output logic                               tx_dl_bit
);
    import esb_pkg::*;

    localparam int         IW     = $clog2(RX_DEPTH);
    localparam logic [7:0] DEPTH8 = 8'(RX_DEPTH);
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ d[i]) ? ((c >> 1) ^ ESB_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte
    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    logic [ESB_ADDR_W-1:0] bus_addr;
    logic                  bus_wr_pend;
    logic                  bus_tx_pend;
    logic                  bus_tx_last;
    logic [7:0]            ctrl;
    logic [3:0]            rx_select;
    logic [7:0]            spare_capture [0:3];
    logic [7:0]            spare_stage [0:3];
    logic                  sts_ready;
    logic                  sts_bad;
    logic                  sts_dup;
    logic                  buf_valid;
    logic [7:0]            buf_len;
    logic [IW-1:0]         rd_idx;
    logic [7:0]            rx_mem [0:RX_DEPTH-1];
    logic                  tx_buf_ready;
    logic                  tx_buf_valid;
    logic [8:0]            tx_buf_data;
    logic                  tx_pop;
    wire [7:0] spare_pos5_capture = spare_capture[0];
    wire [7:0] spare_pos6_capture = spare_capture[1];
    wire [7:0] spare_pos7_capture = spare_capture[2];
    wire [7:0] spare_pos8_capture = spare_capture[3];
    wire auto_abort_off               = ctrl[ESB_CTL_ABORT_OFF];
    wire rx_check_off                 = ctrl[ESB_CTL_CHECK_OFF];
    wire duplicate_frame_drop         = ctrl[ESB_CTL_DUP_DROP];
    wire tx_abort_force               = ctrl[ESB_CTL_TX_ABORT];
    wire message_vs_bitpattern_select = ctrl[ESB_CTL_MSG_SEL];
    wire                  addr_ok   = ce && hsel && htrans[1] && hready;
    wire [ESB_ADDR_W-1:0] word_addr = {haddr[ESB_ADDR_W-1:2], 2'b00};
    wire                  is_tx     = (word_addr == ESB_OFF_TXDATA) || (word_addr == ESB_OFF_TXLAST);
    wire                  rd_ok     = addr_ok && !hwrite;
    wire                  rd_pop    = rd_ok && (word_addr == ESB_OFF_RXDATA);
    wire                  wr_now    = ce && bus_wr_pend;
    wire                  wr_ctrl   = wr_now && (bus_addr == ESB_OFF_CTRL);
    wire                  wr_rxsel  = wr_now && (bus_addr == ESB_OFF_RXSEL);
    wire [2:0]            sts_clr   = (wr_now && (bus_addr == ESB_OFF_STATUS)) ? hwdata[2:0] : 3'h0;
    wire [7:0]            rd_byte   = buf_valid ? rx_mem[rd_idx] : 8'h00;
    wire [31:0] status_word = {16'h0, buf_len, 3'h0, tx_buf_ready, buf_valid, sts_dup, sts_bad, sts_ready};
    wire [31:0] read_word =
        (word_addr == ESB_OFF_SPARE5) ? {24'h0, spare_pos5_capture} :
        (word_addr == ESB_OFF_SPARE6) ? {24'h0, spare_pos6_capture} :
        (word_addr == ESB_OFF_SPARE7) ? {24'h0, spare_pos7_capture} :
        (word_addr == ESB_OFF_SPARE8) ? {24'h0, spare_pos8_capture} :
        (word_addr == ESB_OFF_CTRL)   ? {24'h0, ctrl} :
        (word_addr == ESB_OFF_RXSEL)  ? {28'h0, rx_select} :
        (word_addr == ESB_OFF_STATUS) ? status_word :
        (word_addr == ESB_OFF_RXDATA) ? {24'h0, rd_byte} :
        32'h0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_addr    <= '0;
            bus_wr_pend <= 1'b0;
            bus_tx_pend <= 1'b0;
            bus_tx_last <= 1'b0;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            hrdata      <= 32'h0;
        end else if (ce) begin
            if (addr_ok) begin
                bus_addr    <= word_addr;
                bus_wr_pend <= hwrite && !is_tx;
                bus_tx_pend <= hwrite && is_tx;
                bus_tx_last <= (word_addr == ESB_OFF_TXLAST);
                hreadyout   <= !(hwrite && is_tx);
            end else begin
                bus_wr_pend <= 1'b0;
                // Stall the master until the buffer has room
                if (bus_tx_pend && tx_buf_ready) begin
                    bus_tx_pend <= 1'b0;
                    hreadyout   <= 1'b1;
                end
            end
            if (rd_ok)
                hrdata <= read_word;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl      <= ESB_CTRL_RST;
            rx_select <= ESB_RXSEL_RST;
        end else begin
            if (wr_ctrl)
                ctrl <= {1'b0, hwdata[6:3], 2'b00, hwdata[0]}; // R4 R11
            if (wr_rxsel)
                rx_select <= hwdata[3:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Spare bit capture
    wire       sa_take = ce && sa_tick && sa_frame[0];
    wire [2:0] sa_pos  = 3'd7 - sa_frame[3:1]; // R2
    wire       sa_done = sa_take && (sa_frame == ESB_LAST_FRAME);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                spare_stage[i]   <= ESB_SPARE_RST;
                spare_capture[i] <= ESB_SPARE_RST; // R1
            end
        end else if (sa_take) begin
            for (int i = 0; i < 4; i++) begin
                spare_stage[i][sa_pos] <= sa_bits[i]; // R2
                // Last bit lands in the same tick as the commit
                if (sa_done && rx_select[i])
                    spare_capture[i] <= {spare_stage[i][7:1], sa_bits[i]}; // R1 R3
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Transmit controller
    esb_tx_state_t tx_state;
    esb_tx_state_t load_state;
    logic [7:0]    tx_sh;
    logic [7:0]    load_byte;
    logic [2:0]    tx_cnt;
    logic [2:0]    tx_ones;
    logic          tx_stuff;
    logic          tx_last;
    logic          load_last;
    logic          load_pop;
    logic          bos_phase;
    logic          next_bos_phase;
    esb_pair_buffer #(
        .WIDTH (9)
    ) u_tx_buffer (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .in_valid  (bus_tx_pend),
        .in_ready  (tx_buf_ready),
        .in_data   ({bus_tx_last, hwdata[7:0]}),
        .out_valid (tx_buf_valid),
        .out_ready (tx_pop),
        .out_data  (tx_buf_data)
    );
    wire tx_step = ce && tx_dl_tick;
    wire tx_load = tx_step && !tx_abort_force && !tx_stuff && (tx_cnt == 3'd7);
    assign tx_pop = tx_load && load_pop;
    always_comb begin
        load_state     = ESB_TX_FLAG;
        load_byte      = ESB_FLAG;
        load_last      = 1'b0;
        load_pop       = 1'b0;
        next_bos_phase = bos_phase;
        if (!message_vs_bitpattern_select) begin // R10
            if (tx_state == ESB_TX_DATA && !auto_abort_off) begin
                load_state = ESB_TX_ABORT; // R5
                load_byte  = ESB_ABORT_BYTE; // R5
            end else begin
                load_state     = ESB_TX_BOS; // R6
                load_byte      = bos_phase ? {1'b0, bos_code, 1'b0} : ESB_ONES_BYTE;
                next_bos_phase = ~bos_phase;
            end
        end else if (tx_state == ESB_TX_DATA && !tx_last) begin
            if (tx_buf_valid) begin
                load_state = ESB_TX_DATA;
                load_byte  = tx_buf_data[7:0];
                load_last  = tx_buf_data[8];
                load_pop   = 1'b1;
            end else begin
                // Underrun mid frame: close it with an abort
                load_state = ESB_TX_ABORT;
                load_byte  = ESB_ABORT_BYTE;
            end
        end else if (tx_state == ESB_TX_FLAG && tx_buf_valid) begin
            load_state = ESB_TX_DATA;
            load_byte  = tx_buf_data[7:0];
            load_last  = tx_buf_data[8];
            load_pop   = 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state  <= ESB_TX_FLAG;
            tx_sh     <= ESB_FLAG;
            tx_cnt    <= 3'd0;
            tx_ones   <= 3'd0;
            tx_stuff  <= 1'b0;
            tx_last   <= 1'b0;
            bos_phase <= 1'b0;
            tx_dl_bit <= 1'b1;
        end else if (tx_step) begin
            if (tx_abort_force) begin
                tx_dl_bit <= 1'b1; // R9
                tx_state  <= ESB_TX_ABORT; // R9
                tx_cnt    <= 3'd7;
                tx_ones   <= 3'd0;
                tx_stuff  <= 1'b0;
            end else if (tx_stuff) begin
                tx_dl_bit <= 1'b0;
                tx_stuff  <= 1'b0;
                tx_ones   <= 3'd0;
            end else begin
                tx_dl_bit <= tx_sh[0];
                if (tx_state == ESB_TX_DATA) begin
                    tx_ones  <= tx_sh[0] ? tx_ones + 3'd1 : 3'd0;
                    tx_stuff <= tx_sh[0] && (tx_ones == 3'd4);
                end else
                    tx_ones <= 3'd0;
                if (tx_cnt == 3'd7) begin
                    tx_sh     <= load_byte;
                    tx_state  <= load_state;
                    tx_last   <= load_last;
                    bos_phase <= next_bos_phase;
                    tx_cnt    <= 3'd0;
                end else begin
                    tx_sh  <= {1'b0, tx_sh[7:1]};
                    tx_cnt <= tx_cnt + 3'd1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive controller
    logic [2:0]  rx_ones;
    logic [7:0]  rx_byte;
    logic [2:0]  rx_bcnt;
    logic        rx_in_frame;
    logic [7:0]  rx_len;
    logic [15:0] rx_crc;
    logic        rx_match;
    logic        rx_over;
    wire       rx_step    = ce && rx_dl_tick;
    wire       rx_flag    = rx_step && !rx_dl_bit && (rx_ones == 3'd6);
    wire       rx_stuffed = !rx_dl_bit && (rx_ones == 3'd5);
    wire       rx_abort   = rx_step && rx_dl_bit && (rx_ones >= 3'd6);
    wire       rx_data    = rx_step && rx_in_frame && !rx_flag && !rx_abort && !rx_stuffed;
    wire [7:0] rx_next    = {rx_dl_bit, rx_byte[7:1]};
    wire       rx_done    = rx_data && (rx_bcnt == 3'd7);
    wire       rx_fits    = (rx_len < DEPTH8);
    wire       rx_end     = rx_flag && rx_in_frame && (rx_len != 8'h00);
    wire       rx_good    = rx_end && (rx_bcnt == 3'd7) && !rx_over && (rx_len >= ESB_RX_MIN_LEN) &&
                            (rx_check_off || (rx_crc == ESB_CRC_GOOD)); // R7
    wire       rx_drop    = rx_good && duplicate_frame_drop && rx_match && (rx_len == buf_len); // R8
    wire       rx_accept  = rx_good && !rx_drop; // R8
    wire       rx_bad     = (rx_end && !rx_good) || (rx_abort && rx_in_frame && (rx_len != 8'h00));
    // Buffer is overwritten in place; a duplicate rewrites identical bytes
    always_ff @(posedge hclk) begin
        if (rx_done && rx_fits)
            rx_mem[rx_len[IW-1:0]] <= rx_next;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_ones     <= 3'd0;
            rx_byte     <= 8'h00;
            rx_bcnt     <= 3'd0;
            rx_in_frame <= 1'b0;
            rx_len      <= 8'h00;
            rx_crc      <= ESB_CRC_INIT;
            rx_match    <= 1'b0;
            rx_over     <= 1'b0;
        end else if (rx_step) begin
            rx_ones <= rx_dl_bit ? ((rx_ones == 3'd7) ? 3'd7 : rx_ones + 3'd1) : 3'd0;
            if (rx_flag) begin
                rx_in_frame <= 1'b1;
                rx_bcnt     <= 3'd0;
                rx_len      <= 8'h00;
                rx_crc      <= ESB_CRC_INIT;
                rx_match    <= buf_valid;
                rx_over     <= 1'b0;
            end else if (rx_abort) begin
                rx_in_frame <= 1'b0;
            end else if (rx_data) begin
                rx_byte <= rx_next;
                rx_bcnt <= rx_bcnt + 3'd1;
                if (rx_done) begin
                    rx_crc <= crc_byte(rx_crc, rx_next); // R7
                    if (rx_fits) begin
                        rx_len   <= rx_len + 8'h01;
                        rx_match <= rx_match && (rx_len < buf_len) &&
                                    (rx_mem[rx_len[IW-1:0]] == rx_next); // R8
                    end else begin
                        rx_over <= 1'b1;
                    end
                end
            end
        end
    end
    // Hardware set wins over a same cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_ready <= 1'b0;
            sts_bad   <= 1'b0;
            sts_dup   <= 1'b0;
            buf_valid <= 1'b0;
            buf_len   <= 8'h00;
            rd_idx    <= '0;
        end else if (ce) begin
            sts_ready <= rx_accept || (sts_ready && !sts_clr[ESB_STS_READY]);
            sts_bad   <= rx_bad || (sts_bad && !sts_clr[ESB_STS_BAD]);
            sts_dup   <= rx_drop || (sts_dup && !sts_clr[ESB_STS_DUP]);
            if (rx_accept) begin
                buf_valid <= 1'b1;
                buf_len   <= rx_len;
                rd_idx    <= '0;
            end else begin
                if (rx_bad)
                    buf_valid <= buf_valid && rx_match;
                if (rd_pop)
                    rd_idx <= rd_idx + 1'b1;
            end
        end
    end
endmodule : esb_spare_hdlc2

`default_nettype wire

// [verilog/esb_pkg.sv]
package esb_pkg;

    // Register byte offsets
    localparam logic [7:0] ESB_OFF_SPARE5   = 8'h00;
    localparam logic [7:0] ESB_OFF_SPARE6   = 8'h04;
    localparam logic [7:0] ESB_OFF_SPARE7   = 8'h08;
    localparam logic [7:0] ESB_OFF_SPARE8   = 8'h0c;
    localparam logic [7:0] ESB_OFF_CTRL     = 8'h10;
    localparam logic [7:0] ESB_OFF_RXSEL    = 8'h14;
    localparam logic [7:0] ESB_OFF_STATUS   = 8'h18;
    localparam logic [7:0] ESB_OFF_RXDATA   = 8'h1c;
    localparam logic [7:0] ESB_OFF_TXDATA   = 8'h20;
    localparam logic [7:0] ESB_OFF_TXLAST   = 8'h24;
    localparam int         ESB_ADDR_W       = 8;

    // Control register fields
    localparam int ESB_CTL_RSVD      = 7;
    localparam int ESB_CTL_ABORT_OFF = 6;
    localparam int ESB_CTL_CHECK_OFF = 5;
    localparam int ESB_CTL_DUP_DROP  = 4;
    localparam int ESB_CTL_TX_ABORT  = 3;
    localparam int ESB_CTL_MSG_SEL   = 0;

    // Status register fields
    localparam int ESB_STS_READY = 0;
    localparam int ESB_STS_BAD   = 1;
    localparam int ESB_STS_DUP   = 2;
    localparam int ESB_STS_VALID = 3;
    localparam int ESB_STS_ROOM  = 4;
    localparam int ESB_STS_LEN   = 8;

    // Reset values
    localparam logic [7:0] ESB_SPARE_RST = 8'h00;
    localparam logic [7:0] ESB_CTRL_RST  = 8'h00;
    localparam logic [3:0] ESB_RXSEL_RST = 4'h0;

    // Line codes, sent least significant bit first
    localparam logic [7:0]  ESB_FLAG       = 8'h7e;
    localparam logic [7:0]  ESB_ABORT_BYTE = 8'hfe;
    localparam logic [7:0]  ESB_ONES_BYTE  = 8'hff;
    localparam logic [15:0] ESB_CRC_INIT   = 16'hffff;
    localparam logic [15:0] ESB_CRC_POLY   = 16'h8408;
    localparam logic [15:0] ESB_CRC_GOOD   = 16'hf0b8;
    localparam logic [7:0]  ESB_RX_MIN_LEN = 8'h03;
    localparam logic [3:0]  ESB_LAST_FRAME = 4'hf;

    typedef enum logic [2:0] {
        ESB_TX_FLAG  = 3'b000,
        ESB_TX_DATA  = 3'b001,
        ESB_TX_ABORT = 3'b011,
        ESB_TX_BOS   = 3'b010
    } esb_tx_state_t;

endpackage : esb_pkg

// [verilog/esb_pair_buffer.sv]
`timescale 1ns/1ps
`default_nettype none

module esb_pair_buffer #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    logic [WIDTH-1:0] mem [0:1];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;

    wire push = ce && in_valid && in_ready;
    wire pop  = ce && out_valid && out_ready;

    assign in_ready  = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'd1;
            end else if (pop && !push) begin
                count <= count - 2'd1;
            end
        end
    end

endmodule : esb_pair_buffer

`default_nettype wire

// [test/esb_spare_hdlc2_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module esb_spare_hdlc2_checker (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        ce,
    // Bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Transmit link
    input wire logic        tx_dl_tick,
    input wire logic        tx_dl_bit
);
    import esb_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire take = hsel && htrans[1] && hready && ce;
    logic       rd_q, tk_q, ctl_q, abt_q;
    logic [3:0] n_abt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_q, tk_q, ctl_q, abt_q, n_abt} <= '0;
        end else begin
            rd_q  <= take && !hwrite;
            tk_q  <= tx_dl_tick && ce;
            ctl_q <= take && hwrite && haddr == ESB_OFF_CTRL;
            if (ctl_q && hready && ce) abt_q <= hwdata[ESB_CTL_TX_ABORT];
            if (!abt_q) n_abt <= 4'h0;
            else if (tx_dl_tick && ce && n_abt != 4'hc) n_abt <= n_abt + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    AST_HRESP_OKAY: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    AST_READ_NO_WAIT: assert property (take && !hwrite |=> hreadyout)
        else $error("read stalled");
    AST_SPARE_WR_NO_WAIT: assert property (take && hwrite && haddr < ESB_OFF_CTRL |=> hreadyout)
        else $error("spare write stalled");
    AST_SPARE_UPPER_ZERO: assert property (take && !hwrite && haddr < ESB_OFF_CTRL |=> hrdata[31:8] == 24'h0)
        else $error("spare read upper bits set");
    AST_RDATA_HOLD: assert property (!rd_q |-> $stable(hrdata))
        else $error("read data moved");
    AST_TXBIT_ON_TICK: assert property (!tk_q |-> $stable(tx_dl_bit))
        else $error("link bit moved off tick");
    AST_CE_FREEZE: assert property (!ce |=> $stable(hreadyout) && $stable(hrdata) && $stable(tx_dl_bit))
        else $error("state moved with enable low");
    AST_FORCED_ONES: assert property (abt_q && n_abt == 4'hc |-> tx_dl_bit)
        else $error("zero during forced abort");
    AST_TXWR_WAIT: assert property (take && hwrite && haddr == ESB_OFF_TXLAST |=> !hreadyout ##[1:40] hreadyout)
        else $error("tx write wait wrong");
    COV_SPARE_READ: cover property (take && !hwrite && haddr == ESB_OFF_SPARE8);
    COV_ABORT: cover property (n_abt == 4'hc);
    COV_FREEZE: cover property (!ce);
endmodule : esb_spare_hdlc2_checker

bind esb_spare_hdlc2 esb_spare_hdlc2_checker u_chk (.*);

`default_nettype wire

// [test/esb_far_end.sv]
`timescale 1ns/1ps
`default_nettype none

module esb_far_end (
    // Clock
    input  wire logic  hclk,
    // Spare bits
    output logic       sa_tick,
    output logic [3:0] sa_frame,
    output logic [3:0] sa_bits,
    // Line data link
    output logic       rx_dl_tick,
    output logic       rx_dl_bit,
    output logic       tx_dl_tick
);
    import esb_pkg::*;
    logic [2:0] div = 3'h0;
    initial begin
        {sa_tick, sa_frame, sa_bits, rx_dl_tick} = '0;
        rx_dl_bit = 1'b1;
    end
    always @(posedge hclk) begin
        div <= div + 3'h1;
        tx_dl_tick <= div == 3'h0;
    end
    task automatic multiframe(input logic [31:0] w, input int n);
        for (int f = 0; f < n; f++) begin
            sa_frame <= 4'(f);
            for (int p = 0; p < 4; p++) sa_bits[p] <= w[p*8+7-f/2];
            sa_tick <= 1'b1;
            @(posedge hclk);
            sa_tick <= 1'b0;
            sa_bits <= ~sa_bits;
            repeat (2) @(posedge hclk);
        end
    endtask : multiframe
    task automatic rx_bit(input logic b);
        rx_dl_bit <= b;
        rx_dl_tick <= 1'b1;
        @(posedge hclk);
        rx_dl_tick <= 1'b0;
        rx_dl_bit <= ~b;
        @(posedge hclk);
    endtask : rx_bit
    task automatic flag();
        for (int k = 0; k < 8; k++) rx_bit(ESB_FLAG[k]);
    endtask : flag
    task automatic rx_frame(input logic [7:0] q[$], input logic bad);
        logic [15:0] c;
        int          ones;
        c = ESB_CRC_INIT;
        ones = 0;
        foreach (q[i]) for (int k = 0; k < 8; k++) c = (c >> 1) ^ ((c[0] ^ q[i][k]) ? ESB_CRC_POLY : 16'h0000);
        c = ~c ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        flag();
        foreach (q[i]) for (int k = 0; k < 8; k++) begin
            rx_bit(q[i][k]);
            ones = q[i][k] ? ones + 1 : 0;
            if (ones == 5) begin
                rx_bit(1'b0);
                ones = 0;
            end
        end
        flag();
    endtask : rx_frame
endmodule : esb_far_end

`default_nettype wire

// [test/e1_spare_bit_link_hdlc2_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module e1_spare_bit_link_hdlc2_ctrl_tb;
    import esb_pkg::*;
    logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, r, w, e;
    logic        sa_tick, rx_dl_tick, rx_dl_bit, tx_dl_tick, tx_dl_bit, hv, ok;
    logic [3:0]  sa_frame, sa_bits, sel;
    logic [5:0]  bos_code;
    logic [31:0] seed = 32'h46;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          n;
    logic [7:0]  sp[4] = '{default: 8'h00};
    logic [7:0]  pl[$];
    logic [7:0]  cc[5] = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h20};
    logic        bd[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    esb_spare_hdlc2 DUT (.hready(hreadyout), .*);
    esb_far_end far (.*);
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
        n_compared++;
        if (y !== x) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", s, x, y);
        end
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic spares();
        for (int p = 0; p < 4; p++) begin
            bus(8'(p*4), 1'b0, 32'h0);
            chk("spare", {24'h0, sp[p]}, r);
        end
    endtask : spares
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////
    initial begin
        {hresetn, ce, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'b010;
        bos_code = 6'h00;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ce <= 1'b1;
        bos_code <= 6'(rnd());
        for (int i = 0; i < 5; i++) bus(8'(i*4), 1'b1, rnd() & 32'h7f);
        bus(8'h40, 1'b1, rnd());
        spares();
        bus(8'h40, 1'b0, 32'h0);
        chk("unmapped", 32'h0, r);
        bus(ESB_OFF_CTRL, 1'b1, 32'h7f);
        bus(ESB_OFF_CTRL, 1'b0, 32'h0);
        chk("control", 32'h79, r);
        bus(ESB_OFF_CTRL, 1'b1, 32'h01);
        bus(ESB_OFF_TXLAST, 1'b1, rnd());
        bus(ESB_OFF_CTRL, 1'b1, 32'h08);
        repeat (120) @(posedge hclk);
        n = 0;
        repeat (128) begin
            @(posedge hclk);
            n += (tx_dl_bit === 1'b1);
        end
        chk("abort ones", 32'd128, n);
        bus(ESB_OFF_CTRL, 1'b1, 32'h00);
        ce <= 1'b0;
        repeat (3) @(posedge hclk);
        ce <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            sel = (k == 0) ? 4'hf : 4'(rnd());
            bus(ESB_OFF_RXSEL, 1'b1, {28'h0, sel});
            w = rnd();
            far.multiframe(w, 15);
            spares();
            far.multiframe(w, 16);
            for (int p = 0; p < 4; p++) if (sel[p]) sp[p] = w[p*8 +: 8];
            spares();
        end
        for (int i = 0; i < 4; i++) pl.push_back(8'(rnd()));
        hv = 1'b0;
        foreach (cc[i]) begin
            bus(ESB_OFF_CTRL, 1'b1, {24'h0, cc[i]});
            bus(ESB_OFF_STATUS, 1'b1, 32'h7);
            far.rx_frame(pl, bd[i]);
            ok = !bd[i] || cc[i][ESB_CTL_CHECK_OFF];
            e = !ok ? 32'h2 : (cc[i][ESB_CTL_DUP_DROP] && hv) ? 32'h4 : 32'h1;
            hv = ok && !bd[i];
            bus(ESB_OFF_STATUS, 1'b0, 32'h0);
            chk("status", e, r & 32'h7);
        end
        end_sim();
    end
endmodule : e1_spare_bit_link_hdlc2_ctrl_tb

`default_nettype wire
